// [logic/nand_seq_pkg.sv]
// Shared constants for the serial NAND link: opcodes, feature fields, timing, host registers.
// Assumes a 100 MHz core clock on both ends and a mode-0 serial link.
package nand_seq_pkg;
   // ****************************************
   // Clock and timing
   // ****************************************
   localparam int CLK_MHZ = 100;
   localparam int T_PROG_US = 300;
   localparam int T_READ_US = 25;
   localparam int PROG_CYCLES = T_PROG_US * CLK_MHZ;
   localparam int READ_CYCLES = T_READ_US * CLK_MHZ;
   localparam int SCK_HALF = 8;
   // ****************************************
   // Opcodes and feature addresses
   // ****************************************
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_PROG_EXEC = 8'h10;
   localparam logic [7:0] OP_PAGE_READ = 8'h13;
   localparam logic [7:0] OP_SET_FEAT = 8'h1f;
   localparam logic [7:0] OP_GET_FEAT = 8'h0f;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FAST_READ = 8'h0b;
   localparam logic [7:0] FEAT_CFG = 8'hb0;
   localparam logic [7:0] FEAT_STATUS = 8'hc0;
   localparam logic [2:0] CFG_NOR_ENTER = 3'h5;
   localparam logic [2:0] CFG_NORMAL = 3'h0;
   localparam logic [2:0] CFG_NOR_FAIL = 3'h7;
   localparam int CFG_ECC_BIT = 4;
   localparam logic [7:0] CFG_RESET = 8'h10;
   localparam int ST_OIP_BIT = 0;
   localparam int ST_WEL_BIT = 1;
   localparam int ST_PFAIL_BIT = 3;
   // ****************************************
   // Array layout and bad-block marking
   // ****************************************
   localparam logic [11:0] SPARE_COL = 12'h800;
   localparam logic [7:0] BAD_MARK = 8'h00;
   localparam logic [7:0] ERASED = 8'hff;
   localparam int BLOCKS_1G = 1024;
   localparam int BLOCKS_2G = 2048;
   localparam int MIN_VALID_BLOCK_COUNT_1G = 1004;
   localparam int MIN_VALID_BLOCK_COUNT_2G = 2008;
   localparam int ECC_BITS = 8;
   localparam int ECC_SECTOR = 512;
   localparam int NOR_DUMMY_BITS = 8;
   // ****************************************
   // Host register map and event bits
   // ****************************************
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_BLOCK = 4'h1;
   localparam logic [3:0] REG_EVENT = 4'h2;
   localparam logic [3:0] REG_MASK = 4'h3;
   localparam logic [3:0] REG_RESULT = 4'h4;
   localparam int EV_SCAN_DONE = 0;
   localparam int EV_NOR_DONE = 1;
   localparam int EV_NOR_FAIL = 2;
endpackage

// [logic/nand_link_if.sv]
// Serial link between the flash controller and the flash device.
// Assumes the bench resolves the data-out wire from miso_oe.
`timescale 1ns/1ps
interface nand_link_if;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic miso;
   logic miso_oe;
   modport device (input sclk, input cs_n, input mosi, output miso, output miso_oe);
   modport host (output sclk, output cs_n, output mosi, input miso, input miso_oe);
endinterface

// [logic/nand_flash_dev.sv]
// Serial NAND device end: bad-block marks, feature registers, NOR-style read mode.
// Assumes the link clock is sampled by core_clk and the fuse level is kept outside.
`timescale 1ns/1ps
module nand_flash_dev #(
   parameter int NUM_BLOCKS = nand_seq_pkg::BLOCKS_1G,
   parameter int MIN_VALID = nand_seq_pkg::MIN_VALID_BLOCK_COUNT_1G,
   parameter logic [NUM_BLOCKS-1:0] BAD_MAP = '0,
   parameter int PROG_CYCLES = nand_seq_pkg::PROG_CYCLES,
   parameter int READ_CYCLES = nand_seq_pkg::READ_CYCLES
) (
   input wire logic core_clk,
   input wire logic arst_n,
   nand_link_if.device link,
   input wire logic nor_fuse,
   output logic nor_fuse_burn,
   output logic nor_mode,
   output logic ecc_on,
   output logic valid_ok,
   output logic busy
);
   import nand_seq_pkg::*;
   localparam int BLK_W = $clog2(NUM_BLOCKS);

   // ****************************************
   // Link synchronisers
   // ****************************************
   logic [2:0] sclk_q;
   logic [1:0] cs_q;
   logic [1:0] mosi_q;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sclk_q <= 3'h0;
         cs_q <= 2'h3;
         mosi_q <= 2'h0;
      end else begin
         sclk_q <= {sclk_q[1:0], link.sclk};
         cs_q <= {cs_q[0], link.cs_n};
         mosi_q <= {mosi_q[0], link.mosi};
      end
   end
   logic rise;
   logic fall;
   assign rise = sclk_q[1] & ~sclk_q[2];
   assign fall = ~sclk_q[1] & sclk_q[2];

   // ****************************************
   // Block quality figures
   // ****************************************
   function automatic int count_bad(input logic [NUM_BLOCKS-1:0] m);
      int n;
      n = 0;
      for (int i = 0; i < NUM_BLOCKS; i++) begin
         n = n + int'(m[i]);
      end
      return n;
   endfunction
   assign valid_ok = (NUM_BLOCKS - count_bad(BAD_MAP)) >= MIN_VALID;

   // ****************************************
   // Command engine
   // ****************************************
   logic [31:0] in_q, in_d;
   logic [15:0] cnt_q, cnt_d;
   logic [7:0] op_q, op_d;
   logic [7:0] fa_q, fa_d;
   logic [7:0] cfg_q, cfg_d;
   logic [11:0] col_q, col_d;
   logic [BLK_W-1:0] blk_q, blk_d;
   logic [5:0] page_q, page_d;
   logic [15:0] bsy_q, bsy_d;
   logic wel_q, wel_d;
   logic pfail_q, pfail_d;
   logic pend_q, pend_d;
   logic nor_q, nor_d;
   logic nfail_q, nfail_d;
   logic burn_q, burn_d;
   logic [7:0] out_q, out_d;
   logic oe_q, oe_d;
   logic [15:0] hdr;
   logic is_rd;
   logic [15:0] k;
   logic [11:0] col_k;
   logic [7:0] byte_v;

   always_comb begin
      is_rd = (op_q == OP_READ) || (op_q == OP_FAST_READ);
      hdr = 16'hffff;
      if (op_q == OP_GET_FEAT) begin
         hdr = 16'h0010;
      end else if (is_rd && nor_q && op_q == OP_FAST_READ) begin
         hdr = 16'(32 + NOR_DUMMY_BITS);
      end else if (is_rd) begin
         hdr = 16'h0020;
      end
      k = cnt_q - hdr;
      col_k = col_q + k[14:3];
      if (op_q == OP_GET_FEAT && fa_q == FEAT_STATUS) begin
         byte_v = 8'h00;
         byte_v[ST_OIP_BIT] = bsy_q != 16'h0000;
         byte_v[ST_WEL_BIT] = wel_q;
         byte_v[ST_PFAIL_BIT] = pfail_q;
      end else if (op_q == OP_GET_FEAT && fa_q == FEAT_CFG) begin
         byte_v = cfg_q;
         if (nor_q) begin
            byte_v[2:0] = CFG_NORMAL;
         end else if (nfail_q) begin
            byte_v[2:0] = CFG_NOR_FAIL;
         end
      end else if (op_q == OP_GET_FEAT) begin
         byte_v = 8'h00;
      end else if (BAD_MAP[blk_q] && (page_q == 6'h00 ||
                   (page_q == 6'h01 && col_k == SPARE_COL))) begin
         byte_v = BAD_MARK;
      end else begin
         byte_v = ERASED;
      end
   end

   always_comb begin
      in_d = in_q;
      cnt_d = cnt_q;
      op_d = op_q;
      fa_d = fa_q;
      cfg_d = cfg_q;
      col_d = col_q;
      blk_d = blk_q;
      page_d = page_q;
      bsy_d = bsy_q;
      wel_d = wel_q;
      pfail_d = pfail_q;
      pend_d = pend_q;
      nor_d = nor_q | nor_fuse;
      nfail_d = nfail_q;
      burn_d = 1'b0;
      out_d = out_q;
      oe_d = oe_q;
      if (bsy_q != 16'h0000) begin
         bsy_d = bsy_q - 16'h0001;
         if (bsy_q == 16'h0001 && pend_q) begin
            pend_d = 1'b0;
            if (pfail_q) begin
               nfail_d = 1'b1;
            end else begin
               nor_d = 1'b1;
               burn_d = 1'b1;
            end
         end
      end
      if (cs_q[1]) begin
         cnt_d = 16'h0000;
         oe_d = 1'b0;
      end else if (rise) begin
         in_d = {in_q[30:0], mosi_q[1]};
         if (cnt_q != 16'hffff) begin
            cnt_d = cnt_q + 16'h0001;
         end
         if (cnt_d == 16'h0008) begin
            op_d = in_d[7:0];
            if (in_d[7:0] == OP_WREN) begin
               wel_d = 1'b1;
            end
         end else if (cnt_d == 16'h0010 && op_q == OP_GET_FEAT) begin
            fa_d = in_d[7:0];
         end else if (cnt_d == 16'h0018) begin
            if (op_q == OP_SET_FEAT && in_d[15:8] == FEAT_CFG) begin
               cfg_d = in_d[7:0];
            end
            if (is_rd && !nor_q) begin
               col_d = in_d[11:0];
            end
         end else if (cnt_d == 16'h0020) begin
            if (op_q == OP_PROG_EXEC && wel_q) begin
               wel_d = 1'b0;
               bsy_d = 16'(PROG_CYCLES);
               pfail_d = BAD_MAP[in_d[BLK_W+5:6]];
               pend_d = cfg_q[2:0] == CFG_NOR_ENTER && in_d[23:0] == 24'h000000;
            end
            if (op_q == OP_PAGE_READ) begin
               blk_d = in_d[BLK_W+5:6];
               page_d = in_d[5:0];
               bsy_d = 16'(READ_CYCLES);
            end
            if (is_rd && nor_q) begin
               col_d = in_d[11:0];
            end
         end
      end else if (fall && cnt_q >= hdr && cnt_q != 16'h0000) begin
         oe_d = 1'b1;
         if (k[2:0] == 3'h0) begin
            out_d = byte_v;
         end else begin
            out_d = {out_q[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         in_q <= 32'h00000000;
         cnt_q <= 16'h0000;
         op_q <= 8'h00;
         fa_q <= 8'h00;
         cfg_q <= CFG_RESET;
         col_q <= 12'h000;
         blk_q <= '0;
         page_q <= 6'h00;
         bsy_q <= 16'h0000;
         wel_q <= 1'b0;
         pfail_q <= 1'b0;
         pend_q <= 1'b0;
         nor_q <= 1'b0;
         nfail_q <= 1'b0;
         burn_q <= 1'b0;
         out_q <= 8'h00;
         oe_q <= 1'b0;
      end else begin
         in_q <= in_d;
         cnt_q <= cnt_d;
         op_q <= op_d;
         fa_q <= fa_d;
         cfg_q <= cfg_d;
         col_q <= col_d;
         blk_q <= blk_d;
         page_q <= page_d;
         bsy_q <= bsy_d;
         wel_q <= wel_d;
         pfail_q <= pfail_d;
         pend_q <= pend_d;
         nor_q <= nor_d;
         nfail_q <= nfail_d;
         burn_q <= burn_d;
         out_q <= out_d;
         oe_q <= oe_d;
      end
   end

   assign link.miso = out_q[7];
   assign link.miso_oe = oe_q;
   assign nor_fuse_burn = burn_q;
   assign nor_mode = nor_q;
   assign ecc_on = cfg_q[CFG_ECC_BIT];
   assign busy = bsy_q != 16'h0000;
endmodule // nand_flash_dev

// [logic/nand_flash_host.sv]
// Flash controller end: bad-block scan and the NOR-style read enabling sequence.
// Assumes software on a plain register port and a device on the serial link.
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
module nand_flash_host (
   input wire logic core_clk,
   input wire logic arst_n,
   nand_link_if.host link,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   output logic irq
);
   import nand_seq_pkg::*;
   typedef enum {S_IDLE, S_PRD, S_PPOLL, S_SPARE, S_SF1, S_WE, S_PE, S_NPOLL,
                 S_SF0, S_VER} seq_t;

   // ****************************************
   // Shift engine
   // ****************************************
   logic [1:0] miso_q;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         miso_q <= 2'h0;
      end else begin
         miso_q <= {miso_q[0], link.miso};
      end
   end
   logic run_q, run_d, tail_q, tail_d, done_q, done_d, sclk_q, sclk_d, cs_q, cs_d;
   logic mosi_q, mosi_d, go;
   logic [3:0] div_q, div_d;
   logic [39:0] tx_q, tx_d, go_tx;
   logic [5:0] bit_q, bit_d, n_q, n_d, go_n;
   logic [7:0] rx_q, rx_d;
   always_comb begin
      run_d = run_q;
      tail_d = tail_q;
      done_d = 1'b0;
      sclk_d = sclk_q;
      cs_d = cs_q;
      mosi_d = mosi_q;
      div_d = div_q;
      tx_d = tx_q;
      bit_d = bit_q;
      n_d = n_q;
      rx_d = rx_q;
      if (go && !run_q) begin
         run_d = 1'b1;
         cs_d = 1'b0;
         tx_d = go_tx;
         mosi_d = go_tx[39];
         n_d = go_n;
         bit_d = 6'h00;
         div_d = 4'h0;
      end else if (run_q) begin
         div_d = div_q + 4'h1;
         if (div_q == 4'(SCK_HALF - 1)) begin
            div_d = 4'h0;
            if (tail_q) begin
               tail_d = 1'b0;
               run_d = 1'b0;
               done_d = 1'b1;
            end else if (!sclk_q) begin
               sclk_d = 1'b1;
               bit_d = bit_q + 6'h01;
               rx_d = {rx_q[6:0], miso_q[1]};
            end else begin
               sclk_d = 1'b0;
               tx_d = {tx_q[38:0], 1'b0};
               mosi_d = tx_q[38];
               if (bit_q == n_q) begin
                  cs_d = 1'b1;
                  tail_d = 1'b1;
               end
            end
         end
      end
   end
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         run_q <= 1'b0;
         tail_q <= 1'b0;
         done_q <= 1'b0;
         sclk_q <= 1'b0;
         cs_q <= 1'b1;
         mosi_q <= 1'b0;
         div_q <= 4'h0;
         tx_q <= 40'h0;
         bit_q <= 6'h00;
         n_q <= 6'h00;
         rx_q <= 8'h00;
      end else begin
         run_q <= run_d;
         tail_q <= tail_d;
         done_q <= done_d;
         sclk_q <= sclk_d;
         cs_q <= cs_d;
         mosi_q <= mosi_d;
         div_q <= div_d;
         tx_q <= tx_d;
         bit_q <= bit_d;
         n_q <= n_d;
         rx_q <= rx_d;
      end
   end
   assign link.sclk = sclk_q;
   assign link.cs_n = cs_q;
   assign link.mosi = mosi_q;

   // ****************************************
   // Sequencer and registers
   // ****************************************
   seq_t st_q, st_d;
   logic pg_q, pg_d, bad_q, bad_d, ok_q, ok_d, pf_q, pf_d;
   logic [10:0] blk_q, blk_d;
   logic [7:0] mark_q, mark_d;
   logic [2:0] ev_q, ev_d, msk_q, msk_d, set;
   logic [15:0] rd_q, rd_d;
   always_comb begin
      st_d = st_q;
      pg_d = pg_q;
      bad_d = bad_q;
      ok_d = ok_q;
      pf_d = pf_q;
      blk_d = blk_q;
      mark_d = mark_q;
      msk_d = msk_q;
      set = 3'h0;
      go = 1'b0;
      go_tx = 40'h0;
      go_n = 6'h00;
      case (st_q)
         S_PRD: begin
            go_tx = {OP_PAGE_READ, 7'h00, blk_q, 5'h00, pg_q, 8'h00};
            go_n = 6'd32;
         end
         S_PPOLL, S_NPOLL: begin
            go_tx = {OP_GET_FEAT, FEAT_STATUS, 24'h0};
            go_n = 6'd24;
         end
         S_SPARE: begin
            go_tx = {OP_READ, 4'h0, SPARE_COL, 16'h0};
            go_n = 6'd40;
         end
         S_SF1: begin
            go_tx = {OP_SET_FEAT, FEAT_CFG, 5'h02, CFG_NOR_ENTER, 16'h0};
            go_n = 6'd24;
         end
         S_WE: begin
            go_tx = {OP_WREN, 32'h0};
            go_n = 6'd8;
         end
         S_PE: begin
            go_tx = {OP_PROG_EXEC, 32'h0};
            go_n = 6'd32;
         end
         S_SF0: begin
            go_tx = {OP_SET_FEAT, FEAT_CFG, 5'h02, CFG_NORMAL, 16'h0};
            go_n = 6'd24;
         end
         S_VER: begin
            go_tx = {OP_GET_FEAT, FEAT_CFG, 24'h0};
            go_n = 6'd24;
         end
         default: begin
         end
      endcase
      go = st_q != S_IDLE && !done_q;
      case (st_q)
         S_IDLE: begin
            if (reg_wr && reg_addr == REG_CTRL && reg_wdata[0]) begin
               st_d = S_PRD;
               pg_d = 1'b0;
               bad_d = 1'b0;
            end else if (reg_wr && reg_addr == REG_CTRL && reg_wdata[1]) begin
               st_d = S_SF1;
               ok_d = 1'b0;
               pf_d = 1'b0;
            end
         end
         S_PRD: if (done_q) begin
            st_d = S_PPOLL;
         end
         S_PPOLL: if (done_q && !rx_q[ST_OIP_BIT]) begin
            st_d = S_SPARE;
         end
         S_SPARE: if (done_q) begin
            mark_d = rx_q;
            bad_d = bad_q | (rx_q != ERASED);
            pg_d = 1'b1;
            st_d = pg_q ? S_IDLE : S_PRD;
            set[EV_SCAN_DONE] = pg_q;
         end
         S_SF1: if (done_q) begin
            st_d = S_WE;
         end
         S_WE: if (done_q) begin
            st_d = S_PE;
         end
         S_PE: if (done_q) begin
            st_d = S_NPOLL;
         end
         S_NPOLL: if (done_q && !rx_q[ST_OIP_BIT]) begin
            pf_d = rx_q[ST_PFAIL_BIT];
            st_d = S_SF0;
         end
         S_SF0: if (done_q) begin
            st_d = S_VER;
         end
         S_VER: if (done_q) begin
            ok_d = rx_q[2:0] == CFG_NORMAL && !pf_q;
            set[EV_NOR_DONE] = 1'b1;
            set[EV_NOR_FAIL] = !(rx_q[2:0] == CFG_NORMAL && !pf_q);
            st_d = S_IDLE;
         end
         default: st_d = S_IDLE;
      endcase
      if (reg_wr && reg_addr == REG_BLOCK && st_q == S_IDLE) begin
         blk_d = reg_wdata[10:0];
      end
      if (reg_wr && reg_addr == REG_MASK) begin
         msk_d = reg_wdata[2:0];
      end
      ev_d = ev_q;
      if (reg_rd && reg_addr == REG_EVENT) begin
         ev_d = 3'h0;
      end
      ev_d = ev_d | set;
      rd_d = 16'h0000;
      if (reg_rd) begin
         case (reg_addr)
            REG_BLOCK: rd_d = {5'h00, blk_q};
            REG_EVENT: rd_d = {13'h0000, ev_q};
            REG_MASK: rd_d = {13'h0000, msk_q};
            REG_RESULT: rd_d = {mark_q, 4'h0, st_q != S_IDLE, pf_q, ok_q, bad_q};
            default: rd_d = 16'h0000;
         endcase
      end
   end
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= S_IDLE;
         pg_q <= 1'b0;
         bad_q <= 1'b0;
         ok_q <= 1'b0;
         pf_q <= 1'b0;
         blk_q <= 11'h000;
         mark_q <= 8'h00;
         ev_q <= 3'h0;
         msk_q <= 3'h0;
         rd_q <= 16'h0000;
      end else begin
         st_q <= st_d;
         pg_q <= pg_d;
         bad_q <= bad_d;
         ok_q <= ok_d;
         pf_q <= pf_d;
         blk_q <= blk_d;
         mark_q <= mark_d;
         ev_q <= ev_d;
         msk_q <= msk_d;
         rd_q <= rd_d;
      end
   end
   assign reg_rdata = rd_q;
   assign irq = |(ev_q & msk_q);
endmodule // nand_flash_host

// [testbench/nand_link_checker.sv]
// Checker for the serial link and the mode outputs of the flash device.
// Assumes the bench instantiates it beside the link interface, on the core clock.
`timescale 1ns/1ps
module nand_link_checker (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe,
   input wire logic nor_fuse,
   input wire logic nor_fuse_burn,
   input wire logic nor_mode,
   input wire logic ecc_on,
   input wire logic busy
);
   // ****************************************
   // Link clock rises counted within a frame
   // ****************************************
   logic sclk_q;
   logic sclk_d;
   logic [7:0] rises_q;
   logic [7:0] rises_d;
   always_comb begin
      sclk_d = sclk;
      rises_d = rises_q;
      if (cs_n) begin
         rises_d = 8'h00;
      end else if (sclk && !sclk_q && rises_q != 8'hff) begin
         rises_d = rises_q + 8'h01;
      end
   end
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sclk_q <= 1'b0;
         rises_q <= 8'h00;
      end else begin
         sclk_q <= sclk_d;
         rises_q <= rises_d;
      end
   end
   // ****************************************
   // Assertions and covers
   // ****************************************
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);
   idle_clock_low_a: assert property (cs_n |-> !sclk)
      else $error("Link clock high outside a frame.");
   clock_half_a: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
      else $error("Link clock high phase is not eight cycles.");
   mosi_steady_a: assert property (sclk && !cs_n |-> $stable(mosi))
      else $error("Host data changed while the link clock was high.");
   miso_on_low_a: assert property ($changed(miso) |-> !sclk)
      else $error("Device data changed while the link clock was high.");
   header_first_a: assert property ($rose(miso_oe) |-> !cs_n && rises_q >= 8'h10)
      else $error("Device drove data before a full header.");
   release_out_a: assert property (cs_n [*6] |-> !miso_oe)
      else $error("Device still drives data after the frame ended.");
   mode_sticky_a: assert property (nor_mode |=> nor_mode)
      else $error("Read mode left the alternate setting.");
   fuse_forces_a: assert property (arst_n && nor_fuse |=> nor_mode)
      else $error("Retained setting did not force the read mode.");
   burn_sets_a: assert property (nor_fuse_burn |-> ##[0:1] nor_mode ##1 !nor_fuse_burn)
      else $error("Setting pulse without the mode becoming active.");
   busy_hold_a: assert property ($rose(busy) |-> busy [*8])
      else $error("Busy dropped too early.");
   ecc_kept_a: assert property (ecc_on)
      else $error("Correction was switched off.");
   cover property ($rose(miso_oe));
   cover property (nor_fuse_burn);
   cover property ($rose(busy));
endmodule // nand_link_checker

// [testbench/test_nand_badblock_and_nor_read_setup.sv]
// Bench joining the flash controller and the flash device over the link interface.
// Assumes the package, interface and both design ends are compiled first.
`timescale 1ns/1ps
module test_nand_badblock_and_nor_read_setup;
   import nand_seq_pkg::*;
   // ****************************************
   // Signals and instances
   // ****************************************
   localparam logic [1023:0] BAD = 1024'h20;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic nor_fuse = 1'b0;
   logic [15:0] reg_rdata;
   logic irq, nor_fuse_burn, nor_mode, ecc_on, valid_ok, busy;
   logic [15:0] rd;
   int mismatches = 0;
   int checks_done = 0;
   int cycles = 0;
   nand_link_if link ();
   nand_flash_dev #(.BAD_MAP(BAD), .PROG_CYCLES(20), .READ_CYCLES(20)) i_nand_flash_dev (
      .core_clk(core_clk), .arst_n(arst_n), .link(link.device), .nor_fuse(nor_fuse),
      .nor_fuse_burn(nor_fuse_burn), .nor_mode(nor_mode), .ecc_on(ecc_on),
      .valid_ok(valid_ok), .busy(busy));
   nand_flash_host i_nand_flash_host (
      .core_clk(core_clk), .arst_n(arst_n), .link(link.host), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .irq(irq));
   nand_link_checker i_nand_link_checker (
      .core_clk(core_clk), .arst_n(arst_n), .sclk(link.sclk), .cs_n(link.cs_n),
      .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe), .nor_fuse(nor_fuse),
      .nor_fuse_burn(nor_fuse_burn), .nor_mode(nor_mode), .ecc_on(ecc_on), .busy(busy));
   // ****************************************
   // Clock, timeout and retained setting
   // ****************************************
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (nor_fuse_burn) begin
         nor_fuse <= 1'b1;
      end
      if (cycles == 60000) begin
         mismatches = mismatches + 1;
         end_of_test();
      end
   end
   // ****************************************
   // Tasks
   // ****************************************
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks_done = checks_done + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   task automatic wait_done();
      int n;
      n = 0;
      repeat (4) @(posedge core_clk);
      reg_read(REG_RESULT, rd);
      while (rd[3] !== 1'b0 && n < 5000) begin
         reg_read(REG_RESULT, rd);
         n = n + 1;
      end
      cmp({15'h0000, rd[3]}, 16'h0000);
   endtask
   task automatic end_of_test();
      if (mismatches == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      repeat (5) @(posedge core_clk);
      arst_n <= 1'b1;
      reg_write(4'hf, 16'hffff);
      reg_read(4'hf, rd);
      cmp(rd, 16'h0000);
      reg_read(REG_EVENT, rd);
      cmp(rd, 16'h0000);
      cmp({15'h0000, valid_ok}, 16'h0001);
      cmp({15'h0000, nor_mode}, 16'h0000);
      reg_write(REG_MASK, 16'h0000);
      reg_write(REG_BLOCK, 16'h0003);
      reg_write(REG_CTRL, 16'h0001);
      wait_done();
      cmp(rd & 16'hff0f, 16'hff00);
      cmp({15'h0000, irq}, 16'h0000);
      reg_write(REG_MASK, 16'h0007);
      @(posedge core_clk);
      #1;
      cmp({15'h0000, irq}, 16'h0001);
      reg_read(REG_EVENT, rd);
      cmp(rd, 16'h0001);
      @(posedge core_clk);
      #1;
      cmp({15'h0000, irq}, 16'h0000);
      reg_read(REG_EVENT, rd);
      cmp(rd, 16'h0000);
      reg_write(REG_BLOCK, 16'h0005);
      reg_write(REG_CTRL, 16'h0001);
      wait_done();
      cmp(rd & 16'hff0f, 16'h0001);
      reg_read(REG_EVENT, rd);
      cmp(rd, 16'h0001);
      reg_write(REG_CTRL, 16'h0002);
      wait_done();
      cmp(rd & 16'h000f, 16'h0003);
      reg_read(REG_EVENT, rd);
      cmp(rd, 16'h0002);
      cmp({15'h0000, nor_mode}, 16'h0001);
      cmp({15'h0000, nor_fuse}, 16'h0001);
      cmp({15'h0000, ecc_on}, 16'h0001);
      @(posedge core_clk);
      arst_n <= 1'b0;
      repeat (5) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      cmp({15'h0000, nor_mode}, 16'h0001);
      reg_write(REG_BLOCK, 16'h0003);
      reg_write(REG_CTRL, 16'h0001);
      reg_write(REG_CTRL, 16'h0002);
      wait_done();
      reg_read(REG_EVENT, rd);
      cmp(rd, 16'h0001);
      end_of_test();
   end
endmodule // test_nand_badblock_and_nor_read_setup
